/* rtl/qecrm_pkg.sv */
// Constants, state and carrier types for the quad-enable and continuous-read block
package qecrm_pkg;
	// ==========================================================
	// Instruction codes
	localparam logic [7:0] CMD_RDSR1 = 8'h05;
	localparam logic [7:0] CMD_RDSR2 = 8'h35;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	// ==========================================================
	// Status layout and reset values
	localparam int QE_POS = 1;
	localparam logic [2:0] QE_REQ_CODE = 3'h5;
	localparam logic [7:0] SR_RST = 8'h00;
	// ==========================================================
	// Mode bits
	localparam logic [3:0] MODE_ENTER_HI = 4'ha;
	localparam logic [3:0] NIB_ALL_ONES = 4'hf;
	localparam logic [3:0] MRST_CYC = 4'h8;
	localparam logic [3:0] MODE_NIB_LAST = 4'h1;
	// ==========================================================
	// Frame bit counts and lanes
	localparam logic [3:0] CMD_BIT_LAST = 4'h7;
	localparam logic [3:0] WR_BIT_LAST = 4'hf;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] OE_NONE = 4'h0;
	localparam logic [3:0] OE_SO = 4'h2;
	localparam logic [3:0] OE_QUAD = 4'hf;
	localparam logic [3:0] DQ_IDLE = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_ADDR = 3'b010,
		ST_MODE = 3'b011,
		ST_DUMMY = 3'b100,
		ST_DATA = 3'b101,
		ST_RDSR = 3'b110,
		ST_SKIP = 3'b111
	} qecrm_state_e;

	typedef enum logic {
		WS_BYTE = 1'b0,
		WS_DONE = 1'b1
	} qecrm_unused_e;

	typedef struct packed {
		logic [7:0] sr1;
		logic [7:0] sr2;
	} qecrm_status_s;
endpackage : qecrm_pkg

/* rtl/qecrm_flash_ctl.sv */
// Quad-enable status control and continuous quad-I/O read mode tracking
//
// Overview of operation
// - quad enable is status two bit one, code 101b
// - instruction 05h shifts out status register one
// - instruction 35h shifts out status register two
// - two-byte status write with bit one sets enable
// - same write with bit one zero clears enable
// - mode bits with upper nibble A enter continuous
// - mode bits 00h leave continuous after this read
// - eight clocks of all-ones nibbles force exit
`timescale 1ns/1ps
module qecrm_flash_ctl #(
	parameter logic [7:0] QIOR_CMD = 8'heb,
	parameter int ADDR_NIB = 6,
	parameter int DUMMY_CYC = 4
) (
	// Core clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// Serial link
	input wire logic SPI_SCK,
	input wire logic SPI_CS_N,
	input wire logic [3:0] QUAD_DATA_LINES_I,
	output logic [3:0] QUAD_DATA_LINES_O,
	output logic [3:0] QUAD_DATA_LINES_OE,
	// Status
	output logic QUAD_ENABLE_BIT,
	output logic [2:0] QE_REQ
);
	localparam logic [3:0] ADDR_LAST = 4'(ADDR_NIB - 1);
	localparam logic [3:0] DUMMY_LAST = 4'(DUMMY_CYC - 1);

	// ==========================================================
	// Link domain: reset and status copy crossings
	logic rst_m_r, rst_s;
	logic pub_m_r, pub_s_r, pub_d_r;
	logic pub_tgl_r;
	qecrm_pkg::qecrm_status_s sr_r, sr_s_r, hold_r;

	always_ff @(posedge SPI_SCK)
	begin
		rst_m_r <= SRST;
		rst_s <= rst_m_r;
	end

	// Core status is stable whenever the toggle is seen, so the word is safe to take
	always_ff @(posedge SPI_SCK)
	begin
		if (rst_s)
		begin
			pub_m_r <= 1'b0;
			pub_s_r <= 1'b0;
			pub_d_r <= 1'b0;
			sr_s_r <= {qecrm_pkg::SR_RST, qecrm_pkg::SR_RST};
		end
		else
		begin
			pub_m_r <= pub_tgl_r;
			pub_s_r <= pub_m_r;
			pub_d_r <= pub_s_r;
			if (pub_s_r != pub_d_r)
				sr_s_r <= sr_r;
		end
	end

	// ==========================================================
	// Link domain: frame decoder, cleared by chip select
	qecrm_pkg::qecrm_state_e st_r, cur;
	logic [3:0] cnt_r;
	logic [7:0] cmd_r, sh_r, mode_r;
	logic [7:0] cmd_nxt, mode_nxt;
	logic [15:0] wr_r, wr_nxt;
	logic wr_tgl_r;
	logic cont_r;
	logic [3:0] ff_cnt_r;
	logic ff_ok_r;
	logic mode_end, ff_hit;

	// A frame opens with an address when continuous mode is held
	always_comb
	begin
		cur = st_r;
		if (st_r == qecrm_pkg::ST_IDLE)
			cur = cont_r ? qecrm_pkg::ST_ADDR : qecrm_pkg::ST_CMD;
	end

	assign cmd_nxt = {cmd_r[6:0], QUAD_DATA_LINES_I[0]};
	assign mode_nxt = {mode_r[3:0], QUAD_DATA_LINES_I};
	assign wr_nxt = {wr_r[14:0], QUAD_DATA_LINES_I[0]};
	assign mode_end = (cur == qecrm_pkg::ST_MODE) && (cnt_r == qecrm_pkg::MODE_NIB_LAST);
	assign ff_hit = cont_r && ff_ok_r && (QUAD_DATA_LINES_I == qecrm_pkg::NIB_ALL_ONES)
		&& (ff_cnt_r == qecrm_pkg::MRST_CYC - qecrm_pkg::CNT_ONE);

	always_ff @(posedge SPI_SCK or posedge SPI_CS_N)
	begin
		if (SPI_CS_N)
		begin
			st_r <= qecrm_pkg::ST_IDLE;
			cnt_r <= qecrm_pkg::CNT_ZERO;
		end
		else
		begin
			st_r <= cur;
			cnt_r <= cnt_r + qecrm_pkg::CNT_ONE;
			unique case (cur)
				qecrm_pkg::ST_CMD:
					if (cnt_r == qecrm_pkg::CMD_BIT_LAST)
					begin
						cnt_r <= qecrm_pkg::CNT_ZERO;
						if (cmd_nxt == qecrm_pkg::CMD_RDSR1 || cmd_nxt == qecrm_pkg::CMD_RDSR2)
							st_r <= qecrm_pkg::ST_RDSR;
						else if (cmd_nxt == qecrm_pkg::CMD_WRSR)
							st_r <= qecrm_pkg::ST_MODE == cur ? cur : qecrm_pkg::ST_SKIP;
						// Quad read is refused until quad enable is set
						else if (cmd_nxt == QIOR_CMD && sr_s_r.sr2[qecrm_pkg::QE_POS])
							st_r <= qecrm_pkg::ST_ADDR;
						else
							st_r <= qecrm_pkg::ST_SKIP;
					end
				qecrm_pkg::ST_ADDR:
					if (cnt_r == ADDR_LAST)
					begin
						st_r <= qecrm_pkg::ST_MODE;
						cnt_r <= qecrm_pkg::CNT_ZERO;
					end
				qecrm_pkg::ST_MODE:
					if (mode_end)
					begin
						st_r <= qecrm_pkg::ST_DUMMY;
						cnt_r <= qecrm_pkg::CNT_ZERO;
					end
				qecrm_pkg::ST_DUMMY:
					if (cnt_r == DUMMY_LAST)
						st_r <= qecrm_pkg::ST_DATA;
				qecrm_pkg::ST_SKIP:
					if (cmd_r == qecrm_pkg::CMD_WRSR && cnt_r == qecrm_pkg::WR_BIT_LAST)
						cnt_r <= cnt_r;
				qecrm_pkg::ST_IDLE, qecrm_pkg::ST_DATA, qecrm_pkg::ST_RDSR:
					cnt_r <= cnt_r;
			endcase
		end
	end

	// Shift registers need no reset: every frame refills them before use
	always_ff @(posedge SPI_SCK)
	begin
		if (cur == qecrm_pkg::ST_CMD)
			cmd_r <= cmd_nxt;
		if (cur == qecrm_pkg::ST_MODE)
			mode_r <= mode_nxt;
		if (cur == qecrm_pkg::ST_CMD && cnt_r == qecrm_pkg::CMD_BIT_LAST)
			sh_r <= (cmd_nxt == qecrm_pkg::CMD_RDSR1) ? sr_s_r.sr1 : sr_s_r.sr2;
		else if (cur == qecrm_pkg::ST_RDSR)
			sh_r <= {sh_r[6:0], sh_r[7]};
	end

	// Status write data: sixteen bits on the single input line after 01h
	logic wr_busy_r;
	logic [3:0] wr_cnt_r;
	always_ff @(posedge SPI_SCK or posedge SPI_CS_N)
	begin
		if (SPI_CS_N)
		begin
			wr_busy_r <= 1'b0;
			wr_cnt_r <= qecrm_pkg::CNT_ZERO;
		end
		else if (cur == qecrm_pkg::ST_CMD && cnt_r == qecrm_pkg::CMD_BIT_LAST)
			wr_busy_r <= (cmd_nxt == qecrm_pkg::CMD_WRSR);
		else if (wr_busy_r)
		begin
			wr_cnt_r <= wr_cnt_r + qecrm_pkg::CNT_ONE;
			if (wr_cnt_r == qecrm_pkg::WR_BIT_LAST)
				wr_busy_r <= 1'b0;
		end
	end

	always_ff @(posedge SPI_SCK)
	begin
		if (rst_s)
		begin
			wr_tgl_r <= 1'b0;
			wr_r <= 16'h0000;
			hold_r <= {qecrm_pkg::SR_RST, qecrm_pkg::SR_RST};
		end
		else if (wr_busy_r)
		begin
			wr_r <= wr_nxt;
			if (wr_cnt_r == qecrm_pkg::WR_BIT_LAST)
			begin
				hold_r <= wr_nxt;
				wr_tgl_r <= ~wr_tgl_r;
			end
		end
	end

	// ==========================================================
	// Link domain: continuous mode, kept across frames
	always_ff @(posedge SPI_SCK or posedge SPI_CS_N)
	begin
		if (SPI_CS_N)
		begin
			ff_cnt_r <= qecrm_pkg::CNT_ZERO;
			ff_ok_r <= 1'b1;
		end
		else
		begin
			ff_ok_r <= ff_ok_r && (QUAD_DATA_LINES_I == qecrm_pkg::NIB_ALL_ONES);
			if (ff_cnt_r != qecrm_pkg::MRST_CYC)
				ff_cnt_r <= ff_cnt_r + qecrm_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge SPI_SCK)
	begin
		if (rst_s)
			cont_r <= 1'b0;
		else if (mode_end)
			cont_r <= (mode_nxt[7:4] == qecrm_pkg::MODE_ENTER_HI);
		else if (ff_hit)
			cont_r <= 1'b0;
	end

	// ==========================================================
	// Link domain: outputs change on the falling edge
	always_ff @(negedge SPI_SCK or posedge SPI_CS_N)
	begin
		if (SPI_CS_N)
		begin
			QUAD_DATA_LINES_O <= qecrm_pkg::DQ_IDLE;
			QUAD_DATA_LINES_OE <= qecrm_pkg::OE_NONE;
		end
		else if (st_r == qecrm_pkg::ST_RDSR)
		begin
			QUAD_DATA_LINES_O <= {2'b00, sh_r[7], 1'b0};
			QUAD_DATA_LINES_OE <= qecrm_pkg::OE_SO;
		end
		else if (st_r == qecrm_pkg::ST_DATA)
		begin
			// Array contents live elsewhere; the lanes are driven so timing is visible
			QUAD_DATA_LINES_O <= qecrm_pkg::DQ_IDLE;
			QUAD_DATA_LINES_OE <= qecrm_pkg::OE_QUAD;
		end
		else
		begin
			QUAD_DATA_LINES_O <= qecrm_pkg::DQ_IDLE;
			QUAD_DATA_LINES_OE <= qecrm_pkg::OE_NONE;
		end
	end

	// ==========================================================
	// Core domain: status registers
	logic wr_m_r, wr_s_r, wr_d_r, wr_evt;
	assign wr_evt = wr_s_r != wr_d_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			wr_m_r <= 1'b0;
			wr_s_r <= 1'b0;
			wr_d_r <= 1'b0;
			pub_tgl_r <= 1'b0;
			sr_r <= {qecrm_pkg::SR_RST, qecrm_pkg::SR_RST};
			QUAD_ENABLE_BIT <= 1'b0;
			QE_REQ <= qecrm_pkg::QE_REQ_CODE;
		end
		else
		begin
			wr_m_r <= wr_tgl_r;
			wr_s_r <= wr_m_r;
			wr_d_r <= wr_s_r;
			QE_REQ <= qecrm_pkg::QE_REQ_CODE;
			if (wr_evt)
			begin
				sr_r <= hold_r;
				QUAD_ENABLE_BIT <= hold_r.sr2[qecrm_pkg::QE_POS];
				pub_tgl_r <= ~pub_tgl_r;
			end
		end
	end

	// ==========================================================
	// Checks
	sequence s_cmd_done(logic [7:0] code);
		cur == qecrm_pkg::ST_CMD && cnt_r == qecrm_pkg::CMD_BIT_LAST && cmd_nxt == code;
	endsequence

	a_qe_req_code: assert property (@(posedge CORE_CLK) disable iff (SRST)
		QE_REQ == qecrm_pkg::QE_REQ_CODE && QUAD_ENABLE_BIT == sr_r.sr2[qecrm_pkg::QE_POS])
		else $error("quad enable placement wrong");
	a_rdsr1_load: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		s_cmd_done(qecrm_pkg::CMD_RDSR1) |=> st_r == qecrm_pkg::ST_RDSR && sh_r == $past(sr_s_r.sr1))
		else $error("status one not loaded");
	a_rdsr2_load: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		s_cmd_done(qecrm_pkg::CMD_RDSR2) |=> st_r == qecrm_pkg::ST_RDSR && sh_r == $past(sr_s_r.sr2))
		else $error("status two not loaded");
	a_wrsr_set: assert property (@(posedge CORE_CLK) disable iff (SRST)
		wr_evt && hold_r.sr2[qecrm_pkg::QE_POS] |=> QUAD_ENABLE_BIT && sr_r == $past(hold_r))
		else $error("quad enable not set");
	a_wrsr_clear: assert property (@(posedge CORE_CLK) disable iff (SRST)
		wr_evt && !hold_r.sr2[qecrm_pkg::QE_POS] |=> !QUAD_ENABLE_BIT)
		else $error("quad enable not cleared");
	a_cont_entry: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		mode_end && mode_nxt[7:4] == qecrm_pkg::MODE_ENTER_HI |=> cont_r ##0 st_r == qecrm_pkg::ST_DUMMY)
		else $error("continuous mode not entered");
	a_cont_exit: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		mode_end && mode_nxt[7:4] != qecrm_pkg::MODE_ENTER_HI |=> !cont_r)
		else $error("continuous mode not left");
	a_mode_reset: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		ff_hit |=> !cont_r)
		else $error("mode bit reset ignored");
	a_cont_skip: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N || rst_s)
		st_r == qecrm_pkg::ST_IDLE && cont_r |=> st_r == qecrm_pkg::ST_ADDR && cnt_r == qecrm_pkg::CNT_ONE)
		else $error("continuous read expected address first");
endmodule : qecrm_flash_ctl

/* bench/qecrm_host_model.sv */
// Host serial controller model: clock, select and quad data lanes
`timescale 1ns/1ps
module qecrm_host_model #(
	parameter int ADDR_NIB = 6,
	parameter int DUMMY_CYC = 4
) (
	// Link outputs
	output logic sck,
	output logic cs_n,
	output logic [3:0] d,
	// Resolved lane levels
	input wire logic [3:0] q
);
	// ==========================================================
	// Bit cycles, mode 0: change after fall, sample on rise
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		d = 4'h0;
	end

	// Released lanes toggle each cycle so a stale level never looks valid
	task automatic cyc(input logic [3:0] v, input logic drive, output logic [3:0] s);
		d = drive ? v : ~d;
		#7.5 sck = 1'b1;
		s = q;
		#7.5 sck = 1'b0;
	endtask : cyc

	// Clock runs with select high only to flush link-side reset
	task automatic idle(input int n);
		repeat (n)
		begin
			#7.5 sck = 1'b1;
			#7.5 sck = 1'b0;
		end
	endtask : idle

	task automatic open_frame;
		cs_n = 1'b0;
	endtask : open_frame

	task automatic close_frame;
		#7.5 cs_n = 1'b1;
		d = ~d;
		#15;
	endtask : close_frame

	// ==========================================================
	// Byte and frame level
	task automatic send(input logic [7:0] b);
		logic [3:0] s;
		for (int i = 7; i >= 0; i--)
			cyc({3'h0, b[i]}, 1'b1, s);
	endtask : send

	task automatic recv(output logic [7:0] b);
		logic [3:0] s;
		b = 8'h00;
		repeat (8)
		begin
			cyc(4'h0, 1'b0, s);
			b = {b[6:0], s[1]};
		end
	endtask : recv

	// Leaves select low after the first data cycle so the bench can look
	task automatic qframe(input logic with_cmd, input logic [7:0] cmd, input logic [7:0] mode);
		logic [3:0] s;
		open_frame();
		if (with_cmd)
			send(cmd);
		repeat (ADDR_NIB) cyc(4'h1, 1'b1, s);
		cyc(mode[7:4], 1'b1, s);
		cyc(mode[3:0], 1'b1, s);
		repeat (DUMMY_CYC + 1) cyc(4'h0, 1'b0, s);
	endtask : qframe

	task automatic mode_reset;
		logic [3:0] s;
		open_frame();
		repeat (8) cyc(4'hf, 1'b1, s);
		// One released cycle so the exit is visible before select rises
		cyc(4'h0, 1'b0, s);
		close_frame();
	endtask : mode_reset
endmodule : qecrm_host_model

/* bench/qecrm_flash_ctl_tb_top.sv */
// Self-checking bench for quad-enable control and continuous quad read mode
`timescale 1ns/1ps
module qecrm_flash_ctl_tb_top;
	localparam logic [7:0] QUAD_RD = 8'heb;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic sck;
	logic cs_n;
	logic [3:0] h_d;
	logic [3:0] dq_o;
	logic [3:0] dq_oe;
	logic [3:0] dq;
	logic qe;
	logic [2:0] qe_req;
	int n_errors = 0;
	int compares = 0;
	int cyc_cnt = 0;

	always #2.5 core_clk = ~core_clk;
	assign dq = (dq_o & dq_oe) | (h_d & ~dq_oe);

	qecrm_flash_ctl qecrm_flash_ctl_inst (
		.CORE_CLK(core_clk), .SRST(srst), .SPI_SCK(sck), .SPI_CS_N(cs_n),
		.QUAD_DATA_LINES_I(dq), .QUAD_DATA_LINES_O(dq_o), .QUAD_DATA_LINES_OE(dq_oe),
		.QUAD_ENABLE_BIT(qe), .QE_REQ(qe_req)
	);

	qecrm_host_model qecrm_host_model_inst (
		.sck(sck), .cs_n(cs_n), .d(h_d), .q(dq)
	);

	// ==========================================================
	// Shared helpers
	task automatic give_verdict;
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			n_errors++;
		end
	endtask : chk

	task automatic sr_read(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] v;
		qecrm_host_model_inst.open_frame();
		qecrm_host_model_inst.send(cmd);
		qecrm_host_model_inst.recv(v);
		qecrm_host_model_inst.close_frame();
		chk("status", v, exp);
	endtask : sr_read

	task automatic wrsr(input logic [7:0] b1, input logic [7:0] b2);
		qecrm_host_model_inst.open_frame();
		qecrm_host_model_inst.send(8'h01);
		qecrm_host_model_inst.send(b1);
		qecrm_host_model_inst.send(b2);
		qecrm_host_model_inst.close_frame();
		repeat (8) @(posedge core_clk);
		#1;
	endtask : wrsr

	task automatic qread(input logic with_cmd, input logic [7:0] mode, input logic [3:0] exp_oe);
		qecrm_host_model_inst.qframe(with_cmd, QUAD_RD, mode);
		#1;
		chk("data_oe", {4'h0, dq_oe}, {4'h0, exp_oe});
		chk("data_out", {4'h0, dq_o & dq_oe}, 8'h00);
		qecrm_host_model_inst.close_frame();
	endtask : qread

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		chk("qe_req", {5'h0, qe_req}, 8'h05);
		chk("qe_bit", {7'h0, qe}, 8'h00);
		sr_read(8'h05, 8'h00);
		sr_read(8'h35, 8'h00);
	endtask : t_reset

	// Quad read must be ignored while quad enable is still clear
	task automatic t_refuse;
		qread(1'b1, 8'ha5, 4'h0);
	endtask : t_refuse

	task automatic t_qe_set;
		wrsr(8'h5a, 8'h02);
		chk("qe_bit", {7'h0, qe}, 8'h01);
		sr_read(8'h05, 8'h5a);
		sr_read(8'h35, 8'h02);
	endtask : t_qe_set

	task automatic t_cont;
		qread(1'b1, 8'ha5, 4'hf);
		qread(1'b0, 8'ha0, 4'hf);
		qread(1'b0, 8'h00, 4'hf);
		qread(1'b0, 8'ha5, 4'h0);
		qread(1'b1, 8'ha3, 4'hf);
		qread(1'b0, 8'h5a, 4'hf);
		qread(1'b0, 8'ha5, 4'h0);
		qread(1'b1, 8'ha5, 4'hf);
		qecrm_host_model_inst.mode_reset();
		qread(1'b0, 8'ha5, 4'h0);
	endtask : t_cont

	task automatic t_qe_clear;
		wrsr(8'h00, 8'hfd);
		chk("qe_bit", {7'h0, qe}, 8'h00);
		sr_read(8'h35, 8'hfd);
	endtask : t_qe_clear

	// ==========================================================
	// Run control
	always @(posedge core_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 6000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	initial
	begin
		qecrm_host_model_inst.idle(4);
		repeat (3) @(posedge core_clk);
		#1 srst = 1'b0;
		qecrm_host_model_inst.idle(4);
		t_reset();
		t_refuse();
		t_qe_set();
		t_cont();
		t_qe_clear();
		give_verdict();
	end
endmodule : qecrm_flash_ctl_tb_top
